// ### pkg/cpc_cfg.svh
// Register offsets, field positions, reset values and counts of the camera capture port
`ifndef CPC_CFG_SVH
`define CPC_CFG_SVH
`define CPC_OFF_CTRL 8'h00
`define CPC_OFF_STAT 8'h04
`define CPC_OFF_RAW 8'h08
`define CPC_OFF_EN 8'h0c
`define CPC_OFF_MSK 8'h10
`define CPC_OFF_CLR 8'h14
`define CPC_OFF_CODE 8'h18
`define CPC_OFF_UNM 8'h1c
`define CPC_OFF_ORG 8'h20
`define CPC_OFF_EXT 8'h24
`define CPC_OFF_DATA 8'h28
`define CPC_CTRL_START 0
`define CPC_CTRL_SNAP 1
`define CPC_CTRL_CROP 2
`define CPC_CTRL_JPEG 3
`define CPC_CTRL_EMB 4
`define CPC_CTRL_PRISE 5
`define CPC_CTRL_VSHI 6
`define CPC_CTRL_HSHI 7
`define CPC_CTRL_DEC 8
`define CPC_CTRL_WID 10
`define CPC_CTRL_ENA 14
`define CPC_CTRL_MASK 32'h00004fff
`define CPC_EV_FRAME 0
`define CPC_EV_OVF 1
`define CPC_EV_ERR 2
`define CPC_EV_VSYNC 3
`define CPC_EV_LINE 4
`define CPC_EV_W 5
`define CPC_ORG_LINE 16
`define CPC_EXT_LINE 16
`define CPC_CNT_W 14
`define CPC_RESET_VAL 32'h00000000
`define CPC_RESP_OK 2'b00
`define CPC_RESP_ERR 2'b10
`endif

// ### pkg/cpc_pkg.sv
// Types shared by the camera capture port
package cpc_pkg;
  typedef enum logic [1:0] {cpc_dec_all, cpc_dec_half, cpc_dec_quarter, cpc_dec_rsvd} cpc_dec_t;
  typedef enum logic [1:0] {cpc_w8, cpc_w10, cpc_w12, cpc_w14} cpc_width_t;
  typedef enum {cpc_idle, cpc_wait_frame, cpc_active} cpc_state_t;
endpackage

// ### hw/cpc_capture.sv
// Parallel camera capture port with AXI4-Lite register access and DMA request
//
// Summary of operation
// - Continuous or single snapshot capture selectable
// - Boundaries from sync pins or embedded codes
// - Sample on rising or falling pixel clock
// - Vertical sync active level is configurable
// - Horizontal sync active level is configurable
// - Capture all, half or quarter frames
// - Pixel bus width 8, 10, 12, 14
// - Crop starts at programmable first line
// - Crop skips programmable pixel clocks per line
// - Crop captures programmable number of lines
// - Crop captures programmable pixel clocks per line
// - Four byte delimiter codes in embedded mode
// - Captured words in data register, moved by DMA
// - Snapshot waits frame start, one frame, stops
// - Continuous mode keeps transferring frames
// - JPEG disables crop and embedded sync
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/10ps
`include "cpc_cfg.svh"
module cpc_capture import cpc_pkg::*; #(
  parameter int DATA_W = 14
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cam_pclk,
  input wire logic cam_vsync,
  input wire logic cam_hsync,
  input wire logic [DATA_W-1:0] cam_data,
  output logic dma_req,
  input wire logic dma_ack
);

  // ***************************************************************
  // Helpers
  // ***************************************************************
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic code_hit(input logic [7:0] b, input logic [7:0] code, input logic [7:0] unm);
    return ((b ^ code) & unm) == 8'h00;
  endfunction

  // ***************************************************************
  // Registers
  // ***************************************************************
  logic [31:0] ctrl_q, en_q, code_q, unm_q, org_q, ext_q, data_q;
  logic [`CPC_EV_W-1:0] raw_q, ev_set;
  logic data_vld_q;
  logic [7:0] aw_q;
  logic aw_full_q, w_full_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic wr_go, rd_go, pop, snap_done;
  logic [31:0] rd_val;
  logic rd_ok, wr_ok;

  assign wr_go = aw_full_q && w_full_q && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  // Address and data are taken in either order and held until both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_q <= 8'h00;
      wd_q <= `CPC_RESET_VAL;
      ws_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CPC_RESP_OK;
    end else begin
      s_axi_awready <= !aw_full_q && !(s_axi_awvalid && s_axi_awready) && !wr_go;
      s_axi_wready <= !w_full_q && !(s_axi_wvalid && s_axi_wready) && !wr_go;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `CPC_RESP_OK : `CPC_RESP_ERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_ok = 1'b1;
    case (aw_q)
      `CPC_OFF_CTRL, `CPC_OFF_EN, `CPC_OFF_CLR, `CPC_OFF_CODE, `CPC_OFF_UNM, `CPC_OFF_ORG, `CPC_OFF_EXT: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Capture start is cleared by hardware after a snapshot; a write in the same cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `CPC_RESET_VAL;
    end else if (wr_go && aw_q == `CPC_OFF_CTRL) begin
      ctrl_q <= merge(ctrl_q, wd_q, ws_q) & `CPC_CTRL_MASK;
    end else if (snap_done) begin
      ctrl_q[`CPC_CTRL_START] <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q <= `CPC_RESET_VAL;
      code_q <= `CPC_RESET_VAL;
      unm_q <= `CPC_RESET_VAL;
      org_q <= `CPC_RESET_VAL;
      ext_q <= `CPC_RESET_VAL;
    end else if (wr_go) begin
      if (aw_q == `CPC_OFF_EN) en_q <= merge(en_q, wd_q, ws_q) & 32'h0000001f;
      if (aw_q == `CPC_OFF_CODE) code_q <= merge(code_q, wd_q, ws_q);
      if (aw_q == `CPC_OFF_UNM) unm_q <= merge(unm_q, wd_q, ws_q);
      if (aw_q == `CPC_OFF_ORG) org_q <= merge(org_q, wd_q, ws_q) & 32'h1fff3fff;
      if (aw_q == `CPC_OFF_EXT) ext_q <= merge(ext_q, wd_q, ws_q) & 32'h3fff3fff;
    end
  end

  // Events stay set until cleared; a new event in the clearing cycle is kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raw_q <= '0;
    end else if (wr_go && aw_q == `CPC_OFF_CLR && ws_q[0]) begin
      raw_q <= (raw_q & ~wd_q[`CPC_EV_W-1:0]) | ev_set;
    end else begin
      raw_q <= raw_q | ev_set;
    end
  end

  // ***************************************************************
  // Pin synchronisers and pixel strobe
  // ***************************************************************
  localparam int PIN_W = DATA_W + 3;
  logic [PIN_W-1:0] pin_s1_q, pin_s2_q;
  logic pclk_prev_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pclk_prev_q <= 1'b0;
    end else begin
      pin_s1_q <= {cam_pclk, cam_vsync, cam_hsync, cam_data};
      pin_s2_q <= pin_s1_q;
      pclk_prev_q <= pin_s2_q[PIN_W-1];
    end
  end

  logic pclk_s, vs_s, hs_s, pix_stb;
  logic [DATA_W-1:0] pix_s;
  assign pclk_s = pin_s2_q[PIN_W-1];
  assign vs_s = pin_s2_q[PIN_W-2];
  assign hs_s = pin_s2_q[PIN_W-3];
  assign pix_s = pin_s2_q[DATA_W-1:0];
  // Edge found on the synchronised clock; data lags the same two stages so stays aligned
  assign pix_stb = ctrl_q[`CPC_CTRL_PRISE] ? (pclk_s && !pclk_prev_q) : (!pclk_s && pclk_prev_q);

  // ***************************************************************
  // Frame and line boundaries
  // ***************************************************************
  logic jpeg, emb, crop, ena;
  assign jpeg = ctrl_q[`CPC_CTRL_JPEG];
  assign emb = ctrl_q[`CPC_CTRL_EMB] && !jpeg;
  assign crop = ctrl_q[`CPC_CTRL_CROP] && !jpeg;
  assign ena = ctrl_q[`CPC_CTRL_ENA];

  logic h_fs, h_ls, h_le, h_fe, is_code;
  logic emb_fv_q, emb_lv_q, fv_prev_q, lv_prev_q, fv, lv;
  logic fs, fe, ls, le;
  always_comb begin
    h_fs = emb && code_hit(pix_s[7:0], code_q[7:0], unm_q[7:0]);
    h_ls = emb && code_hit(pix_s[7:0], code_q[15:8], unm_q[15:8]);
    h_le = emb && code_hit(pix_s[7:0], code_q[23:16], unm_q[23:16]);
    h_fe = emb && code_hit(pix_s[7:0], code_q[31:24], unm_q[31:24]);
    is_code = h_fs || h_ls || h_le || h_fe;
    if (emb) begin
      fv = h_fs ? 1'b1 : (h_fe ? 1'b0 : emb_fv_q);
      lv = h_ls ? 1'b1 : ((h_le || h_fe) ? 1'b0 : emb_lv_q);
    end else begin
      fv = (vs_s == ctrl_q[`CPC_CTRL_VSHI]);
      lv = fv && (hs_s == ctrl_q[`CPC_CTRL_HSHI]);
    end
  end
  assign fs = pix_stb && fv && !fv_prev_q;
  assign fe = pix_stb && !fv && fv_prev_q;
  assign ls = pix_stb && lv && !lv_prev_q;
  assign le = pix_stb && !lv && lv_prev_q;

  always_ff @(posedge aclk) begin
    if (!aresetn || !ena) begin
      emb_fv_q <= 1'b0;
      emb_lv_q <= 1'b0;
      fv_prev_q <= 1'b0;
      lv_prev_q <= 1'b0;
    end else if (pix_stb) begin
      emb_fv_q <= fv;
      emb_lv_q <= lv;
      fv_prev_q <= fv;
      lv_prev_q <= lv;
    end
  end

  // ***************************************************************
  // Counters, decimation and crop window
  // ***************************************************************
  logic [`CPC_CNT_W-1:0] line_q, pixc_q, pidx;
  logic [1:0] fcnt_q;
  logic sel;
  assign pidx = (ls && !is_code) ? '0 : pixc_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_q <= '0;
      pixc_q <= '0;
      fcnt_q <= 2'b00;
    end else if (pix_stb) begin
      if (fs) fcnt_q <= fcnt_q + 2'b01;
      if (fs) line_q <= '0;
      else if (le && line_q != '1) line_q <= line_q + 1'b1;
      if (is_code) pixc_q <= '0;
      else if (pidx != '1) pixc_q <= pidx + 1'b1;
    end
  end

  always_comb begin
    case (cpc_dec_t'(ctrl_q[`CPC_CTRL_DEC +: 2]))
      cpc_dec_all: sel = 1'b1;
      cpc_dec_half: sel = (fcnt_q[0] == 1'b0);
      cpc_dec_quarter: sel = (fcnt_q == 2'b00);
      default: sel = 1'b1;
    endcase
  end

  logic [`CPC_CNT_W-1:0] first_line, line_off, line_tot, pix_tot;
  logic in_win;
  assign first_line = {1'b0, org_q[`CPC_ORG_LINE +: 13]};
  assign line_off = org_q[`CPC_CNT_W-1:0];
  assign line_tot = ext_q[`CPC_EXT_LINE +: `CPC_CNT_W];
  assign pix_tot = ext_q[`CPC_CNT_W-1:0];
  assign in_win = !crop || ((line_q >= first_line) && (line_q - first_line <= line_tot) &&
                            (pidx >= line_off) && (pidx - line_off <= pix_tot));

  // ***************************************************************
  // Capture sequencing
  // ***************************************************************
  cpc_state_t st_q;
  logic cur_sel_q, take;
  // Only a selected frame uses up the snapshot, so start stays set across skipped frames
  assign snap_done = (st_q == cpc_active) && fe && ctrl_q[`CPC_CTRL_SNAP] && cur_sel_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= cpc_idle;
      cur_sel_q <= 1'b0;
    end else begin
      case (st_q)
        cpc_idle: begin
          if (ena && ctrl_q[`CPC_CTRL_START]) st_q <= cpc_wait_frame;
        end
        cpc_wait_frame: begin
          if (!ena || !ctrl_q[`CPC_CTRL_START]) st_q <= cpc_idle;
          else if (fs) begin
            st_q <= cpc_active;
            cur_sel_q <= sel;
          end
        end
        cpc_active: begin
          if (!ena) st_q <= cpc_idle;
          else if (fe) begin
            // A skipped frame does not use up the snapshot
            if (ctrl_q[`CPC_CTRL_SNAP] && cur_sel_q) st_q <= cpc_idle;
            else st_q <= ctrl_q[`CPC_CTRL_START] ? cpc_wait_frame : cpc_idle;
          end
        end
        default: st_q <= cpc_idle;
      endcase
    end
  end
  assign take = (st_q == cpc_active) && cur_sel_q && pix_stb && lv && !is_code && in_win;

  // ***************************************************************
  // Word packing and data register
  // ***************************************************************
  logic [DATA_W-1:0] pix_m;
  logic [31:0] pack_q;
  logic [1:0] idx_q;
  logic last, flush, push;
  logic [31:0] word;
  always_comb begin
    case (cpc_width_t'(ctrl_q[`CPC_CTRL_WID +: 2]))
      cpc_w8: pix_m = pix_s & DATA_W'(16'h00ff);
      cpc_w10: pix_m = pix_s & DATA_W'(16'h03ff);
      cpc_w12: pix_m = pix_s & DATA_W'(16'h0fff);
      default: pix_m = pix_s & DATA_W'(16'h3fff);
    endcase
    word = pack_q;
    if (ctrl_q[`CPC_CTRL_WID +: 2] == 2'b00) word[idx_q*8 +: 8] = pix_m[7:0];
    else word[idx_q[0]*16 +: 16] = 16'(pix_m);
  end
  assign last = (ctrl_q[`CPC_CTRL_WID +: 2] == 2'b00) ? (idx_q == 2'b11) : idx_q[0];
  assign flush = (st_q == cpc_active) && fe && idx_q != 2'b00;
  assign push = (take && last) || flush;
  assign pop = dma_ack || (rd_go && s_axi_araddr == `CPC_OFF_DATA);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pack_q <= '0;
      idx_q <= 2'b00;
    end else if (flush || !ena) begin
      pack_q <= '0;
      idx_q <= 2'b00;
    end else if (take) begin
      pack_q <= last ? '0 : word;
      idx_q <= last ? 2'b00 : idx_q + 2'b01;
    end
  end

  // A word that finds the register still full is lost and flagged
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_q <= '0;
      data_vld_q <= 1'b0;
      dma_req <= 1'b0;
    end else begin
      if (push && (!data_vld_q || pop)) begin
        data_q <= flush ? pack_q : word;
        data_vld_q <= 1'b1;
      end else if (pop) begin
        data_vld_q <= 1'b0;
      end
      dma_req <= (push && (!data_vld_q || pop)) || (data_vld_q && !pop);
    end
  end

  always_comb begin
    ev_set = '0;
    ev_set[`CPC_EV_FRAME] = (st_q == cpc_active) && fe && cur_sel_q;
    ev_set[`CPC_EV_OVF] = push && data_vld_q && !pop;
    ev_set[`CPC_EV_ERR] = emb && pix_stb && ((h_ls && !fv) || (h_fs && emb_fv_q));
    ev_set[`CPC_EV_VSYNC] = fs;
    ev_set[`CPC_EV_LINE] = le;
  end

  // ***************************************************************
  // Read channel
  // ***************************************************************
  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `CPC_OFF_CTRL: rd_val = ctrl_q;
      `CPC_OFF_STAT: rd_val = {29'h0, data_vld_q, emb_fv_q | fv_prev_q, lv_prev_q};
      `CPC_OFF_RAW: rd_val = 32'(raw_q);
      `CPC_OFF_EN: rd_val = en_q;
      `CPC_OFF_MSK: rd_val = 32'(raw_q) & en_q;
      `CPC_OFF_CLR: rd_val = '0;
      `CPC_OFF_CODE: rd_val = code_q;
      `CPC_OFF_UNM: rd_val = unm_q;
      `CPC_OFF_ORG: rd_val = org_q;
      `CPC_OFF_EXT: rd_val = ext_q;
      `CPC_OFF_DATA: rd_val = data_q;
      default: begin
        rd_val = '0;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `CPC_RESP_OK;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? `CPC_RESP_OK : `CPC_RESP_ERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // cpc_capture

// ### tb/cpc_capture_props.sv
// Bus and DMA request checks on the ports of the camera capture port
`timescale 1ns/10ps
`include "cpc_cfg.svh"
module cpc_capture_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic dma_req,
  input wire logic dma_ack
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************
  // Register bus and DMA request
  // ****************
  chk_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  chk_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_b_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not released");
  chk_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready)
    else $error("read channel not released");
  chk_r_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h28 |=>
    s_axi_rresp == `CPC_RESP_ERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  // Data words may only leave by an acknowledge or a read
  chk_req_hold: assert property (dma_req && !dma_ack && !s_axi_arvalid && !s_axi_rvalid |=> dma_req)
    else $error("dma request dropped unserved");
  chk_req_ack: assert property (dma_req && dma_ack |=> !dma_req)
    else $error("dma request kept after acknowledge");
  cov_wr: cover property (s_axi_bvalid && s_axi_bready);
  cov_req: cover property ($rose(dma_req));
  cov_ack: cover property (dma_req && dma_ack);
endmodule // cpc_capture_props
bind cpc_capture cpc_capture_props cpc_capture_props_inst (.*);

// ### tb/cpc_cam_model.sv
// Camera module model: pixel clock, sync lines and pixel data
`timescale 1ns/10ps
module cpc_cam_model (
  output logic cam_pclk,
  output logic cam_vsync,
  output logic cam_hsync,
  output logic [13:0] cam_data
);
  logic rise_mode = 1'b0;
  logic [13:0] last_q = 14'h0000;
  initial begin
    cam_pclk = 1'b0;
    cam_vsync = 1'b0;
    cam_hsync = 1'b0;
    cam_data = 14'h0000;
  end
  // ****************
  // One pixel period; the clock stands still between calls
  // ****************
  // Data moves on the other edge, so it is stable 80 ns either side of the sampling edge
  task automatic px(input logic [13:0] d, input logic use_d, input logic v, input logic h);
    cam_data = use_d ? d : ~last_q;
    last_q = use_d ? d : last_q;
    cam_vsync = v;
    cam_hsync = h;
    cam_pclk = ~rise_mode;
    #80;
    cam_pclk = rise_mode;
    #80;
  endtask
endmodule // cpc_cam_model

// ### tb/cpc_capture_tb.sv
// Self-checking testbench of the camera capture port
`timescale 1ns/10ps
`include "cpc_cfg.svh"
module cpc_capture_tb import cpc_pkg::*;;
  localparam logic [1:0] OK = `CPC_RESP_OK;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cam_pclk, cam_vsync, cam_hsync, dma_req, dma_ack;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [13:0] cam_data, pv, pm;
  logic va, ha, use_ack;
  logic [31:0] exp_q[$];
  int fails = 0, checks = 0, acks = 0;
  cpc_capture #(.DATA_W(14)) cpc_capture_inst (.*);
  cpc_cam_model cpc_cam_model_inst (.*);
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // ****************
  // Shared tasks
  // ****************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) aw = 1'b0;
      if (s_axi_wready === 1'b1) w = 1'b0;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", 32'(e), 32'(s_axi_bresp));
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    chk("rdata", d, s_axi_rdata);
    chk("rresp", 32'(e), 32'(s_axi_rresp));
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  function automatic logic [31:0] ctl(input logic [7:0] f, input logic [1:0] dc, input logic [1:0] wd);
    return {17'h0, 1'b1, 2'b00, wd, dc, f};
  endfunction
  // Sync pins go inactive first, so enabling never lands inside a stale frame
  task automatic go(input logic [7:0] f, input logic [1:0] dc, input logic [1:0] wd);
    va = f[6];
    ha = f[7];
    cpc_cam_model_inst.rise_mode = f[5];
    cpc_cam_model_inst.cam_vsync = ~f[6];
    cpc_cam_model_inst.cam_hsync = ~f[7];
    wr(`CPC_OFF_CTRL, ctl(f & 8'hfe, dc, wd), OK);
    wr(`CPC_OFF_CTRL, ctl(f, dc, wd), OK);
  endtask
  task automatic cam(input logic [13:0] d, input logic u, input logic v, input logic h);
    cpc_cam_model_inst.px(d, u, v, h);
  endtask
  task automatic frame(input int nl, input int np, input bit keep, input bit wide, input bit emb);
    logic [31:0] w;
    int k;
    w = 32'h0;
    k = 0;
    #7;
    if (emb) cam(14'h0005, 1'b1, 1'b0, 1'b0);
    else begin
      // Frame start leads the first line, as vertical blanking does on a sensor
      cam(pv, 1'b0, ~va, ~ha);
      cam(pv, 1'b0, va, ~ha);
    end
    for (int l = 0; l < nl; l++) begin
      if (emb) cam(14'h00b6, 1'b1, 1'b0, 1'b0);
      for (int p = 0; p < np; p++) begin
        w = wide ? {2'b00, pv & pm, w[31:16]} : {pv[7:0], w[31:8]};
        k++;
        // Queued before the pixel goes out: the word can be read back inside the pixel period
        if (k == (wide ? 2 : 4)) begin
          if (keep) exp_q.push_back(w);
          k = 0;
        end
        cam(pv, 1'b1, va, ha);
        pv = pv + 14'h0131;
      end
      if (emb) cam(14'h00c7, 1'b1, 1'b0, 1'b0);
      else repeat (2) cam(pv, 1'b0, va, ~ha);
    end
    if (emb) cam(14'h00d8, 1'b1, 1'b0, 1'b0);
    repeat (3) cam(pv, 1'b0, ~va, ~ha);
    @(posedge aclk);
  endtask
  // DMA side: pops each word by a data register read or by an acknowledge
  initial begin
    forever begin
      @(posedge aclk);
      if (dma_req === 1'b1 && use_ack === 1'b1) begin
        acks++;
        dma_ack <= 1'b1;
        @(posedge aclk);
        dma_ack <= 1'b0;
      end else if (dma_req === 1'b1) begin
        chk("pending words", 32'h1, 32'(exp_q.size() > 0));
        rd(`CPC_OFF_DATA, exp_q.size() > 0 ? exp_q.pop_front() : 32'h0, OK);
      end
    end
  end
  initial begin
    #1000000;
    fails++;
    test_done();
  end
  // ****************
  // Test sequence
  // ****************
  initial begin
    logic [31:0] cw;
    logic [13:0] t;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, dma_ack, use_ack} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    pv = 14'h0a51;
    {va, ha} = 2'b00;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`CPC_OFF_CTRL, `CPC_RESET_VAL, OK);
    wr(`CPC_OFF_CTRL, 32'hffffbffe, OK);
    rd(`CPC_OFF_CTRL, 32'h00000ffe, OK);
    wr(`CPC_OFF_CODE, 32'hd8c7b6a5, OK);
    rd(`CPC_OFF_CODE, 32'hd8c7b6a5, OK);
    wr(`CPC_OFF_UNM, 32'hffffff0f, OK);
    rd(`CPC_OFF_UNM, 32'hffffff0f, OK);
    wr(`CPC_OFF_STAT, 32'h1, `CPC_RESP_ERR);
    rd(8'h2c, 32'h0, `CPC_RESP_ERR);
    wr(`CPC_OFF_EN, 32'h1, OK);
    go(8'he1, cpc_dec_all, cpc_w8);
    repeat (2) frame(2, 4, 1'b1, 1'b0, 1'b0);
    chk("words left", 32'h0, 32'(exp_q.size()));
    rd(`CPC_OFF_RAW, 32'h00000019, OK);
    rd(`CPC_OFF_MSK, 32'h00000001, OK);
    wr(`CPC_OFF_CLR, 32'h0000001f, OK);
    rd(`CPC_OFF_RAW, 32'h0, OK);
    for (int i = 1; i < 4; i++) begin
      pm = 14'h3fff >> (6 - 2 * i);
      go(8'h01, cpc_dec_all, 2'(i));
      frame(1, 4, 1'b1, 1'b1, 1'b0);
      chk("words left", 32'h0, 32'(exp_q.size()));
    end
    go(8'he3, cpc_dec_all, cpc_w8);
    frame(1, 4, 1'b1, 1'b0, 1'b0);
    frame(1, 4, 1'b0, 1'b0, 1'b0);
    chk("words left", 32'h0, 32'(exp_q.size()));
    rd(`CPC_OFF_CTRL, ctl(8'he2, cpc_dec_all, cpc_w8), OK);
    use_ack = 1'b1;
    for (int i = 1; i < 3; i++) begin
      acks = 0;
      go(8'he1, 2'(i), cpc_w8);
      repeat (4) frame(1, 4, 1'b0, 1'b0, 1'b0);
      chk("dma words", 32'(4 >> i), 32'(acks));
    end
    use_ack = 1'b0;
    wr(`CPC_OFF_ORG, 32'h00010001, OK);
    wr(`CPC_OFF_EXT, 32'h00000003, OK);
    for (int j = 7; j < 11; j++) begin
      t = pv + 14'(j) * 14'h0131;
      cw = {t[7:0], cw[31:8]};
    end
    exp_q.push_back(cw);
    go(8'he5, cpc_dec_all, cpc_w8);
    frame(3, 6, 1'b0, 1'b0, 1'b0);
    chk("words left", 32'h0, 32'(exp_q.size()));
    // Crop window still excludes line 0 and codes are set, so any leak of either loses the word
    go(8'hfd, cpc_dec_all, cpc_w8);
    frame(1, 4, 1'b1, 1'b0, 1'b0);
    chk("words left", 32'h0, 32'(exp_q.size()));
    pv = 14'h0010;
    go(8'h11, cpc_dec_all, cpc_w8);
    frame(1, 4, 1'b1, 1'b0, 1'b1);
    chk("words left", 32'h0, 32'(exp_q.size()));
    test_done();
  end
endmodule // cpc_capture_tb
